// ==== rtl/iir_msg.sv ====
// builds the upstream memory-write address and data from one entry
`timescale 1ns/1ps
`default_nettype none
module iir_msg
  import iir_pkg::*;
(
  input  wire iir_ent_s    ent,
  input  wire logic        lvl,
  output logic      [31:0] addr,
  output logic      [31:0] data
);

  logic hint;

  // ----------------------------------------------------------------
  // address and data words
  // ----------------------------------------------------------------
  always_comb begin
    hint = (ent.dm == IIR_DM_LOWPRI);
    addr = {IIR_MSG_TOP, ent.dest, ent.ext, hint, ent.dstm, 2'b00};
    // edge messages only ever announce an assertion
    data = {16'h0000, ent.trig, (ent.trig ? lvl : 1'b1), 2'b00,
            ent.dstm, ent.dm, ent.vec};
  end

endmodule
`default_nettype wire

// ==== rtl/iir_pkg.sv ====
// shared constants and carrier types of the interrupt redirector
package iir_pkg;

  // ----------------------------------------------------------------
  // table geometry
  // ----------------------------------------------------------------
  localparam int IIR_PINS   = 16;
  localparam int IIR_ENTS   = 24;
  localparam int IIR_TOT    = 48;
  localparam int IIR_HP_ENT = 23;
  localparam int IIR_B_BASE = 24;

  // ----------------------------------------------------------------
  // message encodings
  // ----------------------------------------------------------------
  localparam logic [11:0] IIR_MSG_TOP   = 12'hfee;
  localparam logic [2:0]  IIR_DM_LOWPRI = 3'h1;

  // ----------------------------------------------------------------
  // register map: entry n low word at 8*n, high word at 8*n+4
  // ----------------------------------------------------------------
  localparam logic [9:0]  IIR_ADDR_CTRL = 10'h180;
  localparam logic [9:0]  IIR_ADDR_STAT = 10'h184;
  localparam logic [9:0]  IIR_ADDR_WIN  = 10'h188;
  localparam logic [7:0]  IIR_ENT_WORDS = 8'h60;
  localparam int          IIR_STAT_MISS = 8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  IIR_CTRL_RST  = 2'h3;
  localparam logic [11:0] IIR_WIN_RST   = 12'hfee;

  typedef enum logic [1:0] {
    IIR_UP_MSI,
    IIR_UP_APIC,
    IIR_UP_ASSERT,
    IIR_UP_DEASSERT
  } iir_kind_e;

  typedef struct packed {
    logic [7:0] dest;
    logic [7:0] ext;
    logic       mask;
    logic       trig;
    logic       remote;
    logic       pol;
    logic       pending_request_flag;
    logic       dstm;
    logic [2:0] dm;
    logic [7:0] vec;
  } iir_ent_s;

  typedef struct packed {
    logic        valid;
    iir_kind_e   kind;
    logic [5:0]  idx;
    logic [1:0]  line;
    logic [31:0] addr;
    logic [31:0] data;
  } iir_up_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [31:0] data;
  } iir_wr_s;

endpackage

// ==== rtl/iir_sync.sv ====
// two-stage synchroniser for the interrupt inputs
`timescale 1ns/1ps
`default_nettype none
module iir_sync
  import iir_pkg::*;
#(
  parameter int W = 34
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } iir_sync_s;

  iir_sync_s st;
  iir_sync_s next_st;

  // ----------------------------------------------------------------
  // first stage feeds only the second
  // ----------------------------------------------------------------
  always_comb begin
    next_st    = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      // every source idles high; a zero here would fake a request after reset
      st <= '1;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.s2;

endmodule
`default_nettype wire

// ==== rtl/iir_top.sv ====
// dual-segment interrupt redirector with legacy wire messages
`timescale 1ns/1ps
`default_nettype none
module iir_top
  import iir_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic [15:0] pci_irq_pins_a,
  input  wire logic [15:0] pci_irq_pins_b,
  input  wire logic        hotplug_ctrl_irq_a,
  input  wire logic        hotplug_ctrl_irq_b,
  input  wire iir_wr_s     msi_in,
  output logic             msi_ready,
  input  wire logic        eoi_valid,
  input  wire logic [7:0]  eoi_vector,
  output iir_up_s          up_msg,
  input  wire logic        up_ready
);

  typedef struct packed {
    iir_ent_s [IIR_TOT-1:0] ent;
    logic [IIR_TOT-1:0]     prev;
    logic [3:0]             intx_sent;
    logic [1:0]             ena;
    logic [11:0]            win_base;
    logic [11:0]            win_limit;
    logic                   msi_miss;
    iir_up_s                up;
    logic                   in_ready;
    logic                   wr_pend;
    logic [7:0]             wr_idx;
    logic [31:0]            hrdata;
    logic                   hreadyout;
  } iir_top_s;

  iir_top_s           st;
  iir_top_s           next_st;
  logic [33:0]        pins_s;
  logic [IIR_TOT-1:0] asrt;
  logic [IIR_TOT-1:0] live;
  logic [3:0]         intx_want;
  logic [5:0]         pick;
  logic               pick_ok;
  logic [31:0]        apic_addr;
  logic [31:0]        apic_data;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic has_pin(input int e);
    return (e < IIR_PINS) || (e == IIR_HP_ENT) ||
           ((e >= IIR_B_BASE) && (e < IIR_B_BASE + IIR_PINS)) ||
           (e == IIR_B_BASE + IIR_HP_ENT);
  endfunction

  function automatic logic src_level(input logic [33:0] p, input int e);
    logic r;
    r = 1'b0;
    if (e < IIR_PINS) begin
      r = p[e];
    end else if (e == IIR_HP_ENT) begin
      r = p[32];
    end else if ((e >= IIR_B_BASE) && (e < IIR_B_BASE + IIR_PINS)) begin
      r = p[e - IIR_B_BASE + IIR_PINS];
    end else if (e == IIR_B_BASE + IIR_HP_ENT) begin
      r = p[33];
    end
    return r;
  endfunction

  function automatic logic [1:0] intx_line(input int e);
    logic [1:0] l;
    l = 2'(e);
    if (e == IIR_HP_ENT) begin
      l = 2'h0;
    end else if (e == IIR_B_BASE + IIR_HP_ENT) begin
      l = 2'h1;
    end
    return l;
  endfunction

  function automatic logic in_window(input logic [31:0] a, input logic [11:0] b,
                                     input logic [11:0] l);
    return (a[31:20] >= b) && (a[31:20] <= l);
  endfunction

  // ----------------------------------------------------------------
  // input synchronisation; hot-plug requests are presented active low
  // so that the default low-active polarity suits every source
  // ----------------------------------------------------------------
  iir_sync #(.W(34)) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .din  ({~hotplug_ctrl_irq_b, ~hotplug_ctrl_irq_a, pci_irq_pins_b, pci_irq_pins_a}),
    .dout (pins_s)
  );

  iir_msg u_msg (
    .ent  (st.ent[pick]),
    .lvl  (asrt[pick]),
    .addr (apic_addr),
    .data (apic_data)
  );

  // ----------------------------------------------------------------
  // per-entry levels, legacy wire wants and delivery pick
  // ----------------------------------------------------------------
  always_comb begin
    intx_want = '0;
    pick      = '0;
    pick_ok   = 1'b0;
    for (int e = 0; e < IIR_TOT; e++) begin
      asrt[e] = has_pin(e) & (src_level(pins_s, e) ^ st.ent[e].pol);
      // a disabled controller hands every input to the legacy path
      live[e] = ~st.ent[e].mask & st.ena[e / IIR_ENTS];
      if (asrt[e] && !live[e]) begin
        intx_want[intx_line(e)] = 1'b1;
      end
      if (st.ent[e].pending_request_flag && !pick_ok) begin
        pick    = 6'(e);
        pick_ok = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic       take;
    logic       hit;
    logic       free;
    logic       msi_acc;
    logic       done;
    logic [6:0] ei;
    next_st           = st;
    take              = hsel & htrans[1] & hready;
    hit               = (haddr[31:10] == 22'h0);
    free              = ~st.up.valid | up_ready;
    msi_acc           = st.in_ready & msi_in.valid;
    done              = 1'b0;
    ei                = st.wr_idx[7:1];
    next_st.hreadyout = 1'b1;
    // register writes land in the data phase
    if (st.wr_pend) begin
      if (st.wr_idx < IIR_ENT_WORDS) begin
        if (st.wr_idx[0]) begin
          next_st.ent[ei].dest = hwdata[31:24];
          next_st.ent[ei].ext  = hwdata[23:16];
        end else begin
          next_st.ent[ei].vec  = hwdata[7:0];
          next_st.ent[ei].dm   = hwdata[10:8];
          next_st.ent[ei].dstm = hwdata[11];
          next_st.ent[ei].pol  = hwdata[13];
          next_st.ent[ei].trig = hwdata[15];
          next_st.ent[ei].mask = hwdata[16];
        end
      end else if ({st.wr_idx, 2'b00} == IIR_ADDR_CTRL) begin
        next_st.ena = hwdata[1:0];
      end else if ({st.wr_idx, 2'b00} == IIR_ADDR_STAT) begin
        if (hwdata[IIR_STAT_MISS]) begin
          next_st.msi_miss = 1'b0;
        end
      end else if ({st.wr_idx, 2'b00} == IIR_ADDR_WIN) begin
        next_st.win_base  = hwdata[11:0];
        next_st.win_limit = hwdata[27:16];
      end
    end
    next_st.wr_pend = take & hwrite & hit;
    next_st.wr_idx  = haddr[9:2];
    // end of interrupt stops here: there is no downstream path for it
    if (eoi_valid) begin
      for (int e = 0; e < IIR_TOT; e++) begin
        if (st.ent[e].vec == eoi_vector) begin
          next_st.ent[e].remote = 1'b0;
        end
      end
    end
    if (st.up.valid && up_ready) begin
      next_st.up.valid = 1'b0;
    end
    // inbound messages outrank everything else for an upstream slot that starts the cycle empty
    if (msi_acc) begin
      if (in_window(msi_in.addr, st.win_base, st.win_limit)) begin
        next_st.up.valid = 1'b1;
        next_st.up.kind  = IIR_UP_MSI;
        next_st.up.idx   = '0;
        next_st.up.line  = '0;
        next_st.up.addr  = msi_in.addr;
        next_st.up.data  = msi_in.data;
        done             = 1'b1;
      end else begin
        next_st.msi_miss = 1'b1;
      end
    end
    if (free && !done) begin
      for (int l = 0; l < 4; l++) begin
        if (!done && (intx_want[l] != st.intx_sent[l])) begin
          next_st.up.valid    = 1'b1;
          next_st.up.kind     = intx_want[l] ? IIR_UP_ASSERT : IIR_UP_DEASSERT;
          next_st.up.idx      = '0;
          next_st.up.line     = 2'(l);
          next_st.up.addr     = '0;
          next_st.up.data     = '0;
          next_st.intx_sent[l] = intx_want[l];
          done                = 1'b1;
        end
      end
    end
    if (free && !done && pick_ok) begin
      next_st.up.valid = 1'b1;
      next_st.up.kind  = IIR_UP_APIC;
      next_st.up.idx   = pick;
      next_st.up.line  = '0;
      next_st.up.addr  = apic_addr;
      next_st.up.data  = apic_data;
      next_st.ent[pick].pending_request_flag = 1'b0;
      if (st.ent[pick].trig) begin
        next_st.ent[pick].remote = 1'b1;
      end
    end
    // hardware sets come last so they beat a delivery clear in this cycle, except where a level delivery has just set remote;
    // nothing here touches the posted write path
    for (int e = 0; e < IIR_TOT; e++) begin
      if (live[e] && asrt[e]) begin
        if (st.ent[e].trig) begin
          if (!st.ent[e].remote && !next_st.ent[e].remote) begin
            next_st.ent[e].pending_request_flag = 1'b1;
          end
        end else if (!st.prev[e]) begin
          next_st.ent[e].pending_request_flag = 1'b1;
        end
      end
      next_st.prev[e] = asrt[e];
    end
    next_st.in_ready = ~next_st.up.valid;
    // reads see a write issued just before them
    next_st.hrdata = '0;
    if (take && !hwrite && hit) begin
      if (haddr[9:2] < IIR_ENT_WORDS) begin
        if (haddr[2]) begin
          next_st.hrdata = {next_st.ent[haddr[9:3]].dest, next_st.ent[haddr[9:3]].ext, 16'h0};
        end else begin
          next_st.hrdata = {15'h0, next_st.ent[haddr[9:3]].mask,
                            next_st.ent[haddr[9:3]].trig, next_st.ent[haddr[9:3]].remote,
                            next_st.ent[haddr[9:3]].pol, next_st.ent[haddr[9:3]].pending_request_flag,
                            next_st.ent[haddr[9:3]].dstm, next_st.ent[haddr[9:3]].dm,
                            next_st.ent[haddr[9:3]].vec};
        end
      end else if (haddr[9:0] == IIR_ADDR_CTRL) begin
        next_st.hrdata = {30'h0, next_st.ena};
      end else if (haddr[9:0] == IIR_ADDR_STAT) begin
        next_st.hrdata = {23'h0, next_st.msi_miss, intx_want, next_st.intx_sent};
      end else if (haddr[9:0] == IIR_ADDR_WIN) begin
        next_st.hrdata = {4'h0, next_st.win_limit, 4'h0, next_st.win_base};
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st           <= '0;
      st.ena       <= IIR_CTRL_RST;
      st.win_base  <= IIR_WIN_RST;
      st.win_limit <= IIR_WIN_RST;
      st.in_ready  <= 1'b1;
      st.hreadyout <= 1'b1;
      for (int e = 0; e < IIR_TOT; e++) begin
        st.ent[e].mask <= 1'b1;
        st.ent[e].pol  <= 1'b1;
      end
    end else begin
      st <= next_st;
    end
  end

  assign hreadyout = st.hreadyout;
  assign hresp     = 1'b0;
  assign hrdata    = st.hrdata;
  assign msi_ready = st.in_ready;
  assign up_msg    = st.up;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_apic_load;
    $rose(st.up.valid) && st.up.kind == IIR_UP_APIC;
  endsequence

  a_addr_frame: assert property (s_apic_load |->
    st.up.addr[31:20] == 12'hfee && st.up.addr[1:0] == 2'b00)
    else $error("interrupt write address frame wrong");
  a_hint_mode: assert property (s_apic_load |->
    st.up.addr[3] == (st.up.data[10:8] == 3'h1) && st.up.addr[2] == st.up.data[11])
    else $error("redirection hint or destination mode wrong");
  a_data_zero: assert property (s_apic_load |->
    st.up.data[31:16] == 16'h0 && st.up.data[13:12] == 2'b00)
    else $error("reserved data bits not zero");
  a_edge_status: assert property ((s_apic_load and !st.up.data[15]) |->
    st.up.data[14])
    else $error("edge message without assert status");
  a_level_remote: assert property ((s_apic_load and st.up.data[15]) |->
    st.ent[st.up.idx].remote && st.up.data[7:0] == st.ent[st.up.idx].vec)
    else $error("level delivery did not set remote flag");
  a_eoi_clear: assert property (eoi_valid && st.ent[3].remote &&
    st.ent[3].vec == eoi_vector |=> !st.ent[3].remote)
    else $error("end of interrupt left remote flag set");
  a_intx_rise: assert property ($rose(st.intx_sent[0]) |->
    st.up.valid && st.up.kind == IIR_UP_ASSERT && st.up.line == 2'h0)
    else $error("assert message missing");
  a_intx_fall: assert property ($fell(st.intx_sent[1]) |->
    st.up.valid && st.up.kind == IIR_UP_DEASSERT && st.up.line == 2'h1)
    else $error("deassert message missing");
  a_masked_idle: assert property ($rose(st.ent[2].pending_request_flag) |->
    $past(st.ent[2].mask) == 1'b0)
    else $error("masked entry became pending");
  a_msi_fwd: assert property (msi_ready && msi_in.valid &&
    in_window(msi_in.addr, st.win_base, st.win_limit) |=>
    st.up.valid && st.up.kind == IIR_UP_MSI && st.up.addr == $past(msi_in.addr))
    else $error("inbound message not forwarded");

endmodule
`default_nettype wire

// ==== sim/iir_up_sink.sv ====
// host-side acceptor model for upstream redirector messages
`timescale 1ns/1ps
`default_nettype none
module iir_up_sink
  import iir_pkg::*;
(
  input  wire logic    clk,
  input  wire logic    rstn,
  input  wire iir_up_s up_msg,
  input  wire logic    slow,
  output logic         up_ready
);
  iir_up_s got[$];
  logic    ph;

  // slow mode takes every other edge so held messages are exercised
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ph <= 1'b0;
      up_ready <= 1'b0;
    end else begin
      ph <= ~ph;
      up_ready <= !slow || ph;
      if (up_msg.valid && up_ready) begin
        got.push_back(up_msg);
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench of the interrupt redirector
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import iir_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic        hrdy;
  logic        hresp;
  logic [31:0] hrdata;
  logic [15:0] pins_a = 16'hffff;
  logic [15:0] pins_b = 16'hffff;
  logic        hp_a = 1'b0;
  logic        hp_b = 1'b0;
  iir_wr_s     msi_in = '0;
  logic        msi_ready;
  logic        eoi_valid = 1'b0;
  logic [7:0]  eoi_vector = '0;
  iir_up_s     up_msg;
  logic        up_ready;
  logic        slow = 1'b0;
  int          fail_count = 0;
  int          cmp_count = 0;
  logic [31:0] r;

  always #10 clk = ~clk;

  iir_top dut_u (
    .clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hrdy), .hreadyout(hrdy), .hresp, .hrdata,
    .pci_irq_pins_a(pins_a), .pci_irq_pins_b(pins_b),
    .hotplug_ctrl_irq_a(hp_a), .hotplug_ctrl_irq_b(hp_b),
    .msi_in, .msi_ready, .eoi_valid, .eoi_vector, .up_msg, .up_ready
  );
  iir_up_sink snk (.clk, .rstn, .up_msg, .slow, .up_ready);

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string t);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h want %h", $time, t, s, e);
    end
  endtask

  task automatic end_of_test;
    if (fail_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge clk);
    while (!hrdy) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (!hrdy) @(posedge clk);
    r = hrdata;
  endtask

  task automatic take(output iir_up_s m);
    int n;
    n = 0;
    while (snk.got.size() == 0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    m = '0;
    if (snk.got.size() == 0) chk(0, 1, "no message");
    else m = snk.got.pop_front();
  endtask

  // nothing may reach the host for n cycles
  task automatic quiet(input int n);
    repeat (n) @(posedge clk);
    chk(snk.got.size(), 0, "extra message");
  endtask

  task automatic intx(input logic [3:0] e);
    iir_up_s m;
    take(m);
    chk({m.kind, m.line}, e, "intx");
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    ahb(0, 32'h180, 0);
    chk(r, 32'h3, "ctrl reset");
    chk(32'(hresp), 32'h0, "okay response");
    ahb(0, 32'h188, 0);
    chk(r, 32'h0fee_0fee, "window reset");
    ahb(0, 32'h0, 0);
    chk(r, 32'h0001_2000, "entry reset");
    ahb(0, 32'h400, 0);
    chk(r, 32'h0, "unmapped read");
  endtask

  task automatic t_intx;
    slow <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) pins_a[5*i] <= 1'b0;
      intx({IIR_UP_ASSERT, 2'(i)});
      @(posedge clk) pins_a[5*i] <= 1'b1;
      intx({IIR_UP_DEASSERT, 2'(i)});
    end
    @(posedge clk) pins_a[0] <= 1'b0;
    intx({IIR_UP_ASSERT, 2'h0});
    @(posedge clk) pins_b[4] <= 1'b0;
    @(posedge clk) pins_a[0] <= 1'b1;
    quiet(20);
    @(posedge clk) pins_b[4] <= 1'b1;
    intx({IIR_UP_DEASSERT, 2'h0});
    @(posedge clk) hp_b <= 1'b1;
    intx({IIR_UP_ASSERT, 2'h1});
    @(posedge clk) hp_b <= 1'b0;
    intx({IIR_UP_DEASSERT, 2'h1});
    // with controller A off an unmasked pin still reaches the host
    ahb(1, 32'h180, 32'h2);
    ahb(1, 32'h8, 32'h2000);
    @(posedge clk) pins_a[1] <= 1'b0;
    intx({IIR_UP_ASSERT, 2'h1});
    @(posedge clk) pins_a[1] <= 1'b1;
    intx({IIR_UP_DEASSERT, 2'h1});
    ahb(1, 32'h8, 32'h0001_2000);
    ahb(1, 32'h180, 32'h3);
    slow <= 1'b0;
  endtask

  task automatic t_apic;
    iir_up_s m;
    ahb(1, 32'h14, 32'h1234_0000);
    ahb(1, 32'h10, 32'h2941);
    @(posedge clk) pins_a[2] <= 1'b0;
    take(m);
    chk(m.kind, IIR_UP_APIC, "apic kind");
    chk(m.idx, 32'd2, "apic entry");
    chk(m.addr, 32'hfee1_234c, "apic addr");
    chk(m.data, 32'h4941, "apic data");
    quiet(20);
    @(posedge clk) pins_a[2] <= 1'b1;
    quiet(20);
    ahb(1, 32'hb8, 32'h2077);
    @(posedge clk) hp_a <= 1'b1;
    take(m);
    chk(m.idx, 32'd23, "hotplug entry");
    chk(m.data, 32'h4077, "hotplug data");
    @(posedge clk) hp_a <= 1'b0;
  endtask

  task automatic t_level;
    iir_up_s m;
    ahb(1, 32'h18, 32'ha055);
    ahb(1, 32'hd8, 32'ha055);
    @(posedge clk) pins_a[3] <= 1'b0;
    take(m);
    chk(m.addr, 32'hfee0_0000, "level addr");
    chk(m.data, 32'hc055, "level data");
    @(posedge clk) pins_b[3] <= 1'b0;
    take(m);
    chk(m.idx, 32'd27, "segment b entry");
    quiet(20);
    ahb(0, 32'h18, 0);
    chk(r & 32'h4000, 32'h4000, "remote set");
    @(posedge clk) pins_a[3] <= 1'b1;
    pins_b[3] <= 1'b1;
    @(posedge clk) eoi_valid <= 1'b1;
    eoi_vector <= 8'h55;
    @(posedge clk) eoi_valid <= 1'b0;
    ahb(0, 32'h18, 0);
    chk(r & 32'h4000, 32'h0, "remote a cleared");
    ahb(0, 32'hd8, 0);
    chk(r & 32'h4000, 32'h0, "remote b cleared");
    quiet(10);
  endtask

  task automatic msi(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk) msi_in <= '{valid: 1'b1, addr: a, data: d};
    @(posedge clk);
    while (!msi_ready) @(posedge clk);
    msi_in <= '0;
  endtask

  task automatic t_msi;
    iir_up_s m;
    msi(32'hfee0_0010, 32'h1234);
    take(m);
    chk(m.kind, IIR_UP_MSI, "msi kind");
    chk(m.addr, 32'hfee0_0010, "msi addr");
    chk(m.data, 32'h1234, "msi data");
    msi(32'h1000_0000, 32'h5);
    quiet(10);
    ahb(0, 32'h184, 0);
    chk(r & 32'h100, 32'h100, "window miss flag");
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_intx();
    t_apic();
    t_level();
    t_msi();
    end_of_test();
  end

  // the whole run needs a few hundred cycles; this 40000-cycle margin cuts off a hang
  initial begin
    #(20 * 40000);
    fail_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
